// ---- pkg/ccr_pkg.sv ----
package ccr_pkg;

	// Clock rates and the timebase derived from them.
	localparam int unsigned REF_FREQ_HZ = 50_000_000;
	localparam int unsigned TB_FREQ_HZ = 32_768;
	localparam int unsigned INT_DIV_CYC = REF_FREQ_HZ / TB_FREQ_HZ;
	localparam logic [10:0] INT_DIV_LAST = 11'(INT_DIV_CYC - 1);

	// An external timebase counts as absent after this long without a rising edge.
	localparam int unsigned EXT_TIMEOUT_NS = 61_000;
	localparam int unsigned EXT_TIMEOUT_CYC = EXT_TIMEOUT_NS * (REF_FREQ_HZ / 1_000_000) / 1000;
	localparam logic [11:0] EXT_TIMEOUT_LAST = 12'(EXT_TIMEOUT_CYC - 1);

	// Timebase ticks in one conversion period at 14-bit resolution.
	localparam int unsigned CONV_TICKS_14 = 16_384;

	// Widths of the counting path.
	localparam int unsigned ACC_W = 28;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned RES_W = 14;

	// Register offsets.
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_CHG_LO = 8'h02;
	localparam logic [7:0] ADDR_CHG_HI = 8'h03;
	localparam logic [7:0] ADDR_CNT_LO = 8'h04;
	localparam logic [7:0] ADDR_CNT_HI = 8'h05;

	// Mode register fields.
	localparam int unsigned MODE_EXT_FORCE_POS = 0;
	localparam int unsigned MODE_RES_LSB = 1;
	localparam int unsigned MODE_RUN_POS = 4;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Control and status register fields.
	localparam int unsigned CTRL_ACC_RST_POS = 1;
	localparam int unsigned CTRL_POR_POS = 4;
	localparam int unsigned CTRL_DONE_POS = 5;

	// Data register reset value.
	localparam logic [7:0] DATA_RESET = 8'h00;

	// Bus target address; the value is arbitrary.
	localparam logic [6:0] I2C_ADDR_DEF = 7'h70;

	// Register access strobes from the serial target to the register file.
	typedef struct packed {
		logic start_p;
		logic wr_p;
		logic rd_p;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccr_regbus_t;

	// Serial target phases.
	typedef enum logic [3:0] {
		TGT_IDLE, TGT_ADDR, TGT_A_ACK, TGT_REG, TGT_R_ACK,
		TGT_WR, TGT_W_ACK, TGT_RD, TGT_M_ACK
	} ccr_tgt_phase_t;

endpackage : ccr_pkg

// ---- rtl/ccr_i2c_target.sv ----
`timescale 1ns/100ps
module ccr_i2c_target #(
	parameter logic [6:0] DEV_ADDR = ccr_pkg::I2C_ADDR_DEF
) (
	input logic ref_clk, // System clock.
	input logic rst_b, // Asynchronous reset, active low.
	input logic ce, // Clock enable; state holds while low.
	input logic scl_i, // Bus clock pin level.
	input logic sda_i, // Bus data pin level.
	output logic sda_o, // Data pin drive level, always low.
	output logic sda_oe_n, // Data pin enable, low while driving.
	output logic [7:0] ptr, // Register pointer for read data.
	input logic [7:0] rdata, // Read data at the pointer.
	output ccr_pkg::ccr_regbus_t bus // Access strobes.
);
	import ccr_pkg::*;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		ccr_tgt_phase_t st;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic rw;
		logic nack;
		logic oe_n;
		logic lvl;
		logic [7:0] ptr;
		ccr_regbus_t bus;
	} ccr_tgt_st_t;

	localparam ccr_tgt_st_t TGT_RST = '{scl_s: 3'h7, sda_s: 3'h7, st: TGT_IDLE,
		oe_n: 1'b1, default: '0};

	ccr_tgt_st_t s_r;
	ccr_tgt_st_t s_nxt;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic sda_v;

	// Loads the next read byte, drives its first bit and advances the pointer.
	function automatic ccr_tgt_st_t tgt_load(ccr_tgt_st_t x, logic [7:0] d);
		x.sh = d;
		x.oe_n = d[7];
		x.cnt = 4'h0;
		x.st = TGT_RD;
		x.bus.rd_p = 1'b1;
		x.bus.addr = x.ptr;
		x.ptr = x.ptr + 8'h01;
		return x;
	endfunction : tgt_load

	// Edges are judged on the second and third stages only, never the first.
	assign sda_v = s_r.sda_s[1];
	assign scl_rise = s_r.scl_s[1] & ~s_r.scl_s[2];
	assign scl_fall = ~s_r.scl_s[1] & s_r.scl_s[2];
	assign start_c = s_r.scl_s[1] & s_r.scl_s[2] & ~s_r.sda_s[1] & s_r.sda_s[2];
	assign stop_c = s_r.scl_s[1] & s_r.scl_s[2] & s_r.sda_s[1] & ~s_r.sda_s[2];

	// Byte engine: shifts in on clock rise, shifts out and changes the data pin on clock fall.
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_s = {s_r.scl_s[1:0], scl_i};
		s_nxt.sda_s = {s_r.sda_s[1:0], sda_i};
		s_nxt.lvl = 1'b0;
		s_nxt.bus.start_p = 1'b0;
		s_nxt.bus.wr_p = 1'b0;
		s_nxt.bus.rd_p = 1'b0;
		if (start_c) begin
			s_nxt.st = TGT_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.oe_n = 1'b1;
			s_nxt.bus.start_p = 1'b1;
		end else if (stop_c) begin
			s_nxt.st = TGT_IDLE;
			s_nxt.oe_n = 1'b1;
		end else begin
			case (s_r.st)
				TGT_ADDR, TGT_REG, TGT_WR: begin
					if (scl_rise) begin
						s_nxt.sh = {s_r.sh[6:0], sda_v};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall && s_r.cnt == 4'h8) begin
						s_nxt.cnt = 4'h0;
						s_nxt.oe_n = 1'b0;
						if (s_r.st == TGT_ADDR) begin
							s_nxt.rw = s_r.sh[0];
							s_nxt.st = TGT_A_ACK;
							if (s_r.sh[7:1] != DEV_ADDR) begin
								s_nxt.st = TGT_IDLE;
								s_nxt.oe_n = 1'b1;
							end
						end else if (s_r.st == TGT_REG) begin
							s_nxt.ptr = s_r.sh;
							s_nxt.st = TGT_R_ACK;
						end else begin
							s_nxt.bus.wr_p = 1'b1;
							s_nxt.bus.addr = s_r.ptr;
							s_nxt.bus.wdata = s_r.sh;
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = TGT_W_ACK;
						end
					end
				end
				TGT_A_ACK: begin
					if (scl_fall && s_r.rw) begin
						s_nxt = tgt_load(s_nxt, rdata);
					end else if (scl_fall) begin
						s_nxt.oe_n = 1'b1;
						s_nxt.st = TGT_REG;
					end
				end
				TGT_R_ACK, TGT_W_ACK: begin
					if (scl_fall) begin
						s_nxt.oe_n = 1'b1;
						s_nxt.st = TGT_WR;
					end
				end
				TGT_RD: begin
					if (scl_fall && s_r.cnt == 4'h7) begin
						s_nxt.oe_n = 1'b1;
						s_nxt.st = TGT_M_ACK;
					end else if (scl_fall) begin
						s_nxt.sh = {s_r.sh[6:0], 1'b0};
						s_nxt.oe_n = s_r.sh[6];
						s_nxt.cnt = s_r.cnt + 4'h1;
					end
				end
				TGT_M_ACK: begin
					if (scl_rise) begin
						s_nxt.nack = sda_v;
					end else if (scl_fall && s_r.nack) begin
						s_nxt.st = TGT_IDLE;
					end else if (scl_fall) begin
						s_nxt = tgt_load(s_nxt, rdata);
					end
				end
				default: begin
					s_nxt.oe_n = 1'b1;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= TGT_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign sda_o = s_r.lvl;
	assign sda_oe_n = s_r.oe_n;
	assign ptr = s_r.ptr;
	assign bus = s_r.bus;

endmodule : ccr_i2c_target

// ---- rtl/ccr_counter_top.sv ----
`timescale 1ns/100ps
module ccr_counter_top #(
	parameter int unsigned CONV_TICKS = ccr_pkg::CONV_TICKS_14,
	parameter logic [6:0] DEV_ADDR = ccr_pkg::I2C_ADDR_DEF
) (
	input logic ref_clk, // System clock, 50 MHz.
	input logic rst_b, // Asynchronous reset, active low.
	input logic ce, // Clock enable; all state holds while low.
	input logic scl_i, // Bus clock pin.
	input logic sda_i, // Bus data pin level.
	output logic sda_o, // Data pin drive level.
	output logic sda_oe_n, // Data pin enable, low while driving.
	input logic timebase_pin, // External 32,768 Hz timebase, if fitted.
	input logic sense_input_pin // Modulator bit stream of the sense voltage.
);
	import ccr_pkg::*;

	typedef struct packed {
		logic [7:0] mode;
		logic por;
		logic done;
		logic [ACC_W-1:0] acc;
		logic [CNT_W-1:0] cnt;
		logic [15:0] snap_chg;
		logic [15:0] snap_cnt;
		logic [2:0] tb_s;
		logic [2:0] sen_s;
		logic [11:0] ext_to;
		logic ext_on;
		logic [10:0] div;
		logic [14:0] tcnt;
		logic [14:0] ones;
	} ccr_main_st_t;

	localparam ccr_main_st_t MAIN_RST = '{mode: MODE_RESET, por: 1'b1, default: '0};
	localparam logic [14:0] TICKS_FULL = 15'(CONV_TICKS);

	ccr_main_st_t s_r;
	ccr_main_st_t s_nxt;
	ccr_regbus_t bus;
	logic [7:0] ptr;
	logic [7:0] rdata;
	logic run;
	logic force_ext;
	logic [1:0] res_sh;
	logic [14:0] conv_len;
	logic tb_rise;
	logic int_wrap;
	logic tick;
	logic sen_bit;
	logic conv_done;
	logic [14:0] ones_fin;
	logic signed [RES_W-1:0] conv_res;
	logic clr;
	logic ctrl_rd;

	// Turns the count of ones over a period into a signed 14-bit step.
	// Lower resolutions use a shorter period and are scaled up, so their low bits stay zero unless the result clamps at 8191.
	function automatic logic signed [RES_W-1:0] conv_scale(logic [14:0] ones,
		logic [14:0] len, logic [1:0] sh);
		logic signed [16:0] d;
		d = $signed({2'b00, ones}) - $signed({3'b000, len[14:1]});
		d = d <<< sh;
		if (d > 17'sh01FFF) begin
			d = 17'sh01FFF;
		end
		return d[RES_W-1:0];
	endfunction : conv_scale

	// Serial target holding the byte engine and the register pointer.
	ccr_i2c_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_target (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ce(ce),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_n(sda_oe_n),
		.ptr(ptr),
		.rdata(rdata),
		.bus(bus)
	);

	// Mode decode.
	assign run = s_r.mode[MODE_RUN_POS];
	assign force_ext = s_r.mode[MODE_EXT_FORCE_POS];
	assign res_sh = (s_r.mode[MODE_RES_LSB+:2] == 2'b11) ? 2'b10 : s_r.mode[MODE_RES_LSB+:2];
	assign conv_len = TICKS_FULL >> res_sh;

	// Timebase choice: a live external clock wins; the force bit only silences the oscillator.
	assign tb_rise = s_r.tb_s[1] & ~s_r.tb_s[2];
	assign int_wrap = (s_r.div == INT_DIV_LAST);
	assign tick = s_r.ext_on ? tb_rise : (int_wrap & ~force_ext);

	// Conversion end and its result.
	assign sen_bit = s_r.sen_s[1];
	assign ones_fin = s_r.ones + {14'h0000, sen_bit};
	assign conv_done = run & tick & (s_r.tcnt >= conv_len - 15'h0001);
	assign conv_res = conv_scale(ones_fin, conv_len, res_sh);

	// Register strobes decoded from the serial target.
	assign clr = bus.wr_p & (bus.addr == ADDR_CTRL) & bus.wdata[CTRL_ACC_RST_POS];
	assign ctrl_rd = bus.rd_p & (bus.addr == ADDR_CTRL);

	// Read data: data registers come from the snapshot of this transfer.
	always_comb begin
		rdata = DATA_RESET;
		if (ptr == ADDR_MODE) begin
			rdata = s_r.mode;
		end else if (ptr == ADDR_CTRL) begin
			rdata[CTRL_POR_POS] = s_r.por;
			rdata[CTRL_DONE_POS] = s_r.done;
		end else if (ptr == ADDR_CHG_LO) begin
			rdata = s_r.snap_chg[7:0];
		end else if (ptr == ADDR_CHG_HI) begin
			rdata = s_r.snap_chg[15:8];
		end else if (ptr == ADDR_CNT_LO) begin
			rdata = s_r.snap_cnt[7:0];
		end else if (ptr == ADDR_CNT_HI) begin
			rdata = s_r.snap_cnt[15:8];
		end
	end

	// Next state for the timebase, converter, accumulator and registers.
	always_comb begin
		s_nxt = s_r;
		s_nxt.tb_s = {s_r.tb_s[1:0], timebase_pin};
		s_nxt.sen_s = {s_r.sen_s[1:0], sense_input_pin};

		// Internal oscillator divider; held at zero while the force bit inhibits it.
		s_nxt.div = (int_wrap | force_ext) ? 11'h000 : s_r.div + 11'h001;

		// Presence detector: any rising edge arms it, a long quiet spell drops it.
		if (tb_rise) begin
			s_nxt.ext_on = 1'b1;
			s_nxt.ext_to = 12'h000;
		end else if (s_r.ext_to == EXT_TIMEOUT_LAST) begin
			s_nxt.ext_on = 1'b0;
		end else begin
			s_nxt.ext_to = s_r.ext_to + 12'h001;
		end

		// Integrator samples the sense stream once per timebase tick.
		if (!run) begin
			s_nxt.tcnt = 15'h0000;
			s_nxt.ones = 15'h0000;
		end else if (conv_done) begin
			s_nxt.tcnt = 15'h0000;
			s_nxt.ones = 15'h0000;
		end else if (tick) begin
			s_nxt.tcnt = s_r.tcnt + 15'h0001;
			s_nxt.ones = ones_fin;
		end

		// Completion adds the step and counts it in one cycle; carries fall off the top.
		if (conv_done) begin
			s_nxt.acc = s_r.acc + ACC_W'({{(ACC_W-RES_W){conv_res[RES_W-1]}}, conv_res});
			s_nxt.cnt = s_r.cnt + 16'h0001;
		end
		if (clr) begin
			s_nxt.acc = '0;
			s_nxt.cnt = 16'h0000;
		end

		// Snapshot at every start condition so that one transfer reads one instant.
		if (bus.start_p) begin
			s_nxt.snap_chg = s_r.acc[ACC_W-1:ACC_W-16];
			s_nxt.snap_cnt = s_r.cnt;
		end

		// Register writes; the reset bit is a strobe and always reads back zero.
		if (bus.wr_p && bus.addr == ADDR_MODE) begin
			s_nxt.mode = bus.wdata;
		end
		if (bus.wr_p && bus.addr == ADDR_CTRL && !bus.wdata[CTRL_POR_POS]) begin
			s_nxt.por = 1'b0;
		end

		// Done flag: a read clears it, but a completion in the same cycle wins.
		if (ctrl_rd) begin
			s_nxt.done = 1'b0;
		end
		if (conv_done) begin
			s_nxt.done = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= MAIN_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	default clocking cb_main @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// Counts quiet cycles since the last snapshot for the stability check.
	logic [3:0] quiet_cnt;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			quiet_cnt <= 4'h0;
		end else if (ce && bus.start_p) begin
			quiet_cnt <= 4'h0;
		end else if (ce && quiet_cnt != 4'hF) begin
			quiet_cnt <= quiet_cnt + 4'h1;
		end
	end

	// Stopped monitoring leaves the counter and the accumulator alone.
	property p_idle_hold;
		(ce && !run && !clr) |=> ($stable(s_r.cnt) && $stable(s_r.acc));
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("Counter moved while monitoring was stopped.");

	// A completion bumps the counter by exactly one, wrapping at the top.
	property p_cnt_step;
		(ce && conv_done && !clr) |=> (s_r.cnt == $past(s_r.cnt) + 16'h0001);
	endproperty
	a_cnt_step: assert property (p_cnt_step)
		else $error("Conversion counter did not advance by one.");

	// A completion adds the sign-extended step into the accumulator.
	// Carries out of the top bit are dropped, which is the silent wrap.
	property p_acc_add;
		(ce && conv_done && !clr) |=>
			(s_r.acc == $past(s_r.acc)
			+ ACC_W'({{(ACC_W-RES_W){$past(conv_res[RES_W-1])}}, $past(conv_res)}));
	endproperty
	a_acc_add: assert property (p_acc_add)
		else $error("Accumulator did not take the conversion step.");

	// The reset bit leaves both counts at zero.
	property p_clear;
		(ce && clr) |=> (s_r.acc == '0 && s_r.cnt == 16'h0000);
	endproperty
	a_clear: assert property (p_clear)
		else $error("Accumulator reset left a count behind.");

	// Every completion raises the done flag.
	property p_done_set;
		(ce && conv_done) |=> s_r.done;
	endproperty
	a_done_set: assert property (p_done_set)
		else $error("Done flag missed a completed conversion.");

	// A status read with no completion beside it clears the flag.
	property p_done_clr;
		(ce && ctrl_rd && !conv_done) |=> !s_r.done;
	endproperty
	a_done_clr: assert property (p_done_clr)
		else $error("Done flag survived a status read.");

	// A start condition captures the upper accumulator bits and the counter.
	property p_snap;
		(ce && bus.start_p) |=> (s_r.snap_chg == $past(s_r.acc[ACC_W-1:ACC_W-16])
			&& s_r.snap_cnt == $past(s_r.cnt));
	endproperty
	a_snap: assert property (p_snap)
		else $error("Snapshot does not match the counts at the start.");

	// Between start conditions the snapshot does not move.
	property p_snap_hold;
		(quiet_cnt > 4'h1) |-> ($stable(s_r.snap_chg) && $stable(s_r.snap_cnt));
	endproperty
	a_snap_hold: assert property (p_snap_hold)
		else $error("Snapshot changed inside a transfer.");

	// With the oscillator inhibited and no external clock, the integrator does not move.
	property p_force;
		(ce && run && force_ext && !s_r.ext_on) |=> $stable(s_r.tcnt);
	endproperty
	a_force: assert property (p_force)
		else $error("Internal timebase ticked while inhibited.");

	// Each read strobe advances the pointer by one.
	property p_ptr_inc;
		bus.rd_p |-> (ptr == bus.addr + 8'h01);
	endproperty
	a_ptr_inc: assert property (p_ptr_inc)
		else $error("Register pointer did not advance after a read byte.");

	c_conv: cover property (ce && conv_done);
	c_clear: cover property (ce && clr);
	c_status_read: cover property (ce && ctrl_rd && s_r.done);
	c_ext_clock: cover property ($rose(s_r.ext_on));

endmodule : ccr_counter_top

// ---- verif/ccr_i2c_host.sv ----
`timescale 1ns/100ps
// Behavioural host that owns the bus clock and runs register transfers.
module ccr_i2c_host #(
	parameter logic [6:0] DEV = 7'h70,
	parameter int Q = 5
) (
	input wire logic ref_clk, // System clock, paces the bus only.
	input wire logic sda, // Resolved data line.
	output logic scl, // Bus clock.
	output logic sda_pull // High while the host pulls data low.
);
	logic [7:0] rd [0:7];
	int n_nack = 0;

	// Idle bus: clock high, data released.
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Pins move on falling edges so the device never samples mid-change.
	task automatic wait_clk(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wait_clk

	// Data moves only with the clock low, well after the fall, so no false start is seen.
	task automatic clk_bit(input logic b, output logic r);
		sda_pull = !b;
		wait_clk(Q);
		scl = 1'b1;
		wait_clk(Q);
		r = sda;
		scl = 1'b0;
		wait_clk(Q);
	endtask : clk_bit

	// Start or repeated start; ends with the clock low.
	task automatic start();
		sda_pull = 1'b0;
		wait_clk(Q);
		scl = 1'b1;
		wait_clk(Q);
		sda_pull = 1'b1;
		wait_clk(Q);
		scl = 1'b0;
		wait_clk(Q);
	endtask : start

	// Stop leaves the bus idle.
	task automatic stop();
		sda_pull = 1'b1;
		wait_clk(Q);
		scl = 1'b1;
		wait_clk(Q);
		sda_pull = 1'b0;
		wait_clk(Q);
	endtask : stop

	// Sends a byte and returns the acknowledge level, low when taken.
	task automatic send(input logic [7:0] v, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], r);
		clk_bit(1'b1, nack);
	endtask : send

	// All control goes through bus writes of pointer then data.
	task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
		logic [2:0] a;
		start();
		send({DEV, 1'b0}, a[0]);
		send(ptr, a[1]);
		send(v, a[2]);
		stop();
		if (a != 3'b000) n_nack++;
	endtask : wr

	// Multi-byte values come from one transfer, never split accesses.
	task automatic rd_blk(input logic [7:0] ptr, input int n);
		logic [2:0] a;
		logic r;
		start();
		send({DEV, 1'b0}, a[0]);
		send(ptr, a[1]);
		start();
		send({DEV, 1'b1}, a[2]);
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) begin
				clk_bit(1'b1, r);
				rd[i][j] = r;
			end
			clk_bit(i == n - 1, r);
		end
		stop();
		if (a != 3'b000) n_nack++;
	endtask : rd_blk

	// Address probe; reports the acknowledge level.
	task automatic probe(input logic [6:0] dev, output logic nack);
		start();
		send({dev, 1'b0}, nack);
		stop();
	endtask : probe
endmodule : ccr_i2c_host

// ---- verif/ccr_counter_top_test.sv ----
`timescale 1ns/100ps
// Runs the counter through the host model and checks what the registers report.
module ccr_counter_top_test;
	import ccr_pkg::*;
	localparam int TICKS = 16;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic scl, sda_pull, sda_o, sda_oe_n, sda_wire, nack, pos;
	logic timebase_pin = 1'b0;
	logic sense_input_pin = 1'b1;
	logic tb_on = 1'b1;
	logic [15:0] cnt, chg;
	logic [15:0] cnt_prev;
	logic [7:0] mode;
	int n_fail = 0;
	int check_count = 0;

	// Data line has a pull-up; either party may pull it low.
	assign sda_wire = (!sda_oe_n && !sda_o) || sda_pull ? 1'b0 : 1'b1;

	// Clock generation.
	always #10 ref_clk = ~ref_clk;

	// External timebase, 160 ns period, moved on falling edges; it rests low when not fitted.
	initial begin
		forever begin
			repeat (4) @(negedge ref_clk);
			timebase_pin = tb_on ? !timebase_pin : 1'b0;
		end
	end

	ccr_counter_top #(.CONV_TICKS(TICKS)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
		.scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.timebase_pin(timebase_pin), .sense_input_pin(sense_input_pin));
	ccr_i2c_host #(.DEV(I2C_ADDR_DEF)) i_host (.ref_clk(ref_clk), .sda(sda_wire), .scl(scl),
		.sda_pull(sda_pull));

	task automatic wait_clk(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wait_clk

	task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_byte

	task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_word

	task automatic cmp_flag(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_flag

	// Each conversion at constant sense level adds plus or minus eight; host sees bits 27:12.
	function automatic logic [15:0] exp_charge(input logic [15:0] n, input logic p);
		logic [27:0] acc;
		acc = {12'h000, n} << 3;
		if (!p) acc = -acc;
		return acc[27:12];
	endfunction : exp_charge

	task automatic get_counts();
		i_host.rd_blk(ADDR_CHG_LO, 4);
		chg = {i_host.rd[1], i_host.rd[0]};
		cnt = {i_host.rd[3], i_host.rd[2]};
	endtask : get_counts

	// Sense level changes only while stopped, so no conversion straddles the change.
	task automatic arm(input logic [7:0] m, input logic p);
		i_host.wr(ADDR_MODE, MODE_RESET);
		sense_input_pin = p;
		i_host.wr(ADDR_CTRL, 8'h02);
		i_host.wr(ADDR_MODE, m);
	endtask : arm

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// Watchdog sized a little above the expected run length.
	initial begin
		wait_clk(99000);
		n_fail++;
		$display("watchdog expired");
		conclude();
	end

	// Main sequence: reset state, random runs, then the timebase choices.
	initial begin
		void'($urandom(32'h4BBD0733));
		wait_clk(20);
		rst_b = 1'b1;
		wait_clk(100);
		i_host.rd_blk(ADDR_MODE, 7);
		cmp_byte("mode", MODE_RESET, i_host.rd[0]);
		cmp_byte("ctrl", 8'h10, i_host.rd[1]);
		for (int i = 2; i < 7; i++) cmp_byte("data", DATA_RESET, i_host.rd[i]);
		i_host.probe(I2C_ADDR_DEF ^ 7'h01, nack);
		cmp_flag("foreign address", 1'b1, nack);
		$display("test reset done");
		for (int k = 0; k < 3; k++) begin
			mode = 8'h10 | 8'(($urandom % 4) << 1);
			pos = 1'($urandom);
			arm(mode, pos);
			wait_clk(12000 + $urandom % 1500);
			i_host.wr(ADDR_CHG_HI, 8'($urandom));
			i_host.rd_blk(ADDR_MODE, 6);
			chg = {i_host.rd[3], i_host.rd[2]};
			cnt = {i_host.rd[5], i_host.rd[4]};
			cmp_byte("mode", mode, i_host.rd[0]);
			cmp_byte("ctrl", 8'h20, i_host.rd[1]);
			cmp_word("charge", exp_charge(cnt, pos), chg);
			cmp_flag("count range", 1'b1, cnt > 16'h005A && cnt < 16'h0320);
			i_host.wr(ADDR_MODE, MODE_RESET);
			get_counts();
			mode = cnt[7:0];
			wait_clk(1000);
			get_counts();
			cmp_byte("stopped count", mode, cnt[7:0]);
			i_host.rd_blk(ADDR_CTRL, 1);
			i_host.rd_blk(ADDR_CTRL, 1);
			cmp_byte("ctrl after read", 8'h00, i_host.rd[0]);
			$display("test run %0d done", k);
		end
		tb_on = 1'b0;
		arm(8'h15, 1'b1);
		wait_clk(4000);
		get_counts();
		cmp_word("forced idle count", 16'h0000, cnt);
		arm(8'h14, 1'b1);
		wait_clk(14000);
		get_counts();
		cmp_flag("internal ticks", 1'b1, cnt > 16'h0000 && cnt < 16'h0006);
		tb_on = 1'b1;
		arm(8'h15, 1'b1);
		wait_clk(4000);
		get_counts();
		cmp_flag("external ticks", 1'b1, cnt > 16'h0032);
		// A frozen block must not count the conversions it sleeps through.
		cnt_prev = cnt;
		ce = 1'b0;
		wait_clk(2000);
		ce = 1'b1;
		get_counts();
		cmp_flag("frozen count", 1'b1, cnt != cnt_prev && 16'(cnt - cnt_prev) < 16'h0030);
		cmp_word("missed acks", 16'h0000, 16'(i_host.n_nack));
		$display("test timebase done");
		conclude();
	end
endmodule : ccr_counter_top_test
